/* File: shared/rmtc_pkg.sv */
package rmtc_pkg;
    // timing
    localparam int CLK_HZ      = 40_000_000;
    localparam int T_ACTIVE_US = 250;
    localparam int T_SET_US    = 25;
    localparam int ACTIVE_CYC  = T_ACTIVE_US * (CLK_HZ / 1_000_000);
    localparam int SETTLE_CYC  = T_SET_US * (CLK_HZ / 1_000_000);

    // register indices (byte address on the local port is four times the index)
    localparam logic [7:0] REG_MODE    = 8'h00;
    localparam logic [7:0] REG_GLIDE   = 8'h01;
    localparam logic [7:0] REG_DAC_A   = 8'h02;
    localparam logic [7:0] REG_DAC_B   = 8'h03;
    localparam logic [7:0] REG_DAC_C   = 8'h04;
    localparam logic [7:0] REG_TCFG_AB = 8'h09;
    localparam logic [7:0] REG_TCFG_C  = 8'h0a;
    localparam logic [7:0] REG_SWRST   = 8'h1a;
    localparam logic [7:0] REG_PTRIG   = 8'h1c;
    localparam logic [7:0] REG_DEVID   = 8'h1d;
    localparam logic [7:0] REG_MANUF   = 8'h1e;
    localparam logic [7:0] REG_USID    = 8'h1f;
    localparam logic [5:0] BCAST_PAGE  = 6'h07;

    // field positions
    localparam int OP_BIT    = 5;
    localparam int MASK_LO   = 3;
    localparam int SWRST_BIT = 7;
    localparam int CFG_A_LO  = 6;
    localparam int CFG_B_LO  = 2;
    localparam int CFG_C_LO  = 6;

    // values after reset and power-state codes
    localparam logic [2:0] MODE_FIXED = 3'h2;
    localparam logic [1:0] PWR_ACT    = 2'h0;
    localparam logic [1:0] PWR_RESET  = 2'h1;
    localparam logic [1:0] PWR_LP     = 2'h2;
    localparam logic [7:0] CFG_C_RST  = 8'h04;
    localparam logic [3:0] USID_RST   = 4'h7;

    // link frame coding and local port address width
    localparam logic [2:0] CMD_WR    = 3'h2;
    localparam logic [2:0] CMD_RD    = 3'h3;
    localparam logic [3:0] CMD_EXT   = 4'h0;
    localparam logic [3:0] BCAST_SA  = 4'h0;
    localparam logic [3:0] CMD_LAST  = 4'hc;
    localparam logic [3:0] FRM_LAST  = 4'h8;
    localparam int         BUS_AW    = 7;

    typedef enum logic [1:0] {PS_SHUTDOWN, PS_WAKING, PS_ACTIVE, PS_LOWPWR} rmtc_pwr_t;
    typedef enum logic [2:0] {L_IDLE, L_CMD, L_ADDR, L_DATA, L_RPARK, L_RD, L_RBP} rmtc_lnk_t;
    typedef logic [2:0][7:0] rmtc_dac_t;

    typedef struct packed {
        logic [BUS_AW-1:0] addr;
        logic [7:0]        wdata;
        logic              wr;
        logic              rd;
    } rmtc_bus_t;

    typedef struct packed {
        logic [2:0]      sck_q;
        logic [2:0]      sda_q;
        logic [2:0]      vio_q;
        logic [2:0][1:0] sel_q;
        logic            sck_f;
        logic            sda_f;
        logic            vio_f;
        logic [1:0]      sel_f;
        logic            ssc_arm;
        rmtc_lnk_t       lst;
        logic [3:0]      cnt;
        logic [12:0]     sh;
        logic            par;
        logic            ext;
        logic            bcst;
        logic [3:0]      bc;
        logic [7:0]      ra;
        logic            tx_bit;
        logic            tx_oe;
        logic            r0_op;
        logic [1:0]      pwr;
        logic [2:0]      masks;
        logic [7:0]      glide;
        logic [7:0]      cfg_ab;
        logic [7:0]      cfg_c;
        rmtc_dac_t       shd;
        rmtc_dac_t       dac;
        logic [3:0]      usid;
        logic            perr;
        rmtc_pwr_t       ps;
        logic [15:0]     acnt;
        logic [9:0]      scnt;
        logic            hiz;
        logic [7:0]      rdata;
    } rmtc_state_t;
endpackage

/* File: rtl/rmtc_core.sv */
`timescale 1ns/10ps
// Summary of operation
// - i/o supply low: shutdown, all registers back to defaults, outputs high impedance
// - start-up or power field written 00b via reg 0 or 28 enters active
// - reg 0 bit 5 picks idle (outputs high-z) or operating (outputs driven)
// - power field 10b enters low power; outputs high-z, registers stay accessible
// - power-on reset returns every register and the mode to defaults
// - power field 01b resets all registers then moves to low power
// - reg 26 msb soft-resets all registers except regs 28 and 31
// - each frame ends in odd parity; failing frames are discarded
// - slave ending a read drives data low for first half-cycle, then releases
// - decode register write, register read and extended write sequences
// - every register reachable through extended writes as well as short ones
// - regs 28 to 31 also accept broadcast-addressed writes
// - after a wake command the device becomes operational within activation time
// - three triggers; DACs default to trigger 0, remapped by regs 9 and 10
// - with trigger unmasked, DAC writes go to shadow registers only
// - reg 28 write with trigger set, mask clear copies shadows to DACs
// - masked trigger: DAC writes go straight to destination and output
// - settling window starts on each destination update, at most 25 us
// - power field is reg 28 bits 7:6, mirrored in reg 0 bits 1:0
module rmtc_core #(
    parameter int         ACTIVE_CYCLES = rmtc_pkg::ACTIVE_CYC,
    parameter logic [9:0] MANUF_ID      = 10'h155,  // arbitrary value
    parameter logic [5:0] PROD_ID       = 6'h2a     // arbitrary value
) (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                vio_i,
    input  wire logic                sclk_i,
    input  wire logic                sdata_i,
    output      logic                sdata_o,
    output      logic                sdata_oe_n_o,
    input  wire logic [1:0]          sel_id_i,
    input  wire rmtc_pkg::rmtc_bus_t bus_i,
    output      logic [7:0]          bus_rdata_o,
    output      rmtc_pkg::rmtc_dac_t dac_o,
    output      logic                out_hiz_o,
    output      logic                ready_o,
    output      logic                settle_busy_o
);
    import rmtc_pkg::*;

    rmtc_state_t s;
    rmtc_state_t n;
    logic        rf_bad;
    logic        rf_wr;
    logic [7:0]  rf_a;
    logic [7:0]  rf_d;
    logic        rise;
    logic        fall;
    logic        own;
    logic [12:0] f;

    // trigger that a DAC answers to; code 3 behaves as trigger 2
    function automatic int trig_of(input rmtc_state_t st, input int i);
        logic [1:0] c;
        c = (i == 0) ? st.cfg_ab[CFG_A_LO+:2] :
            (i == 1) ? st.cfg_ab[CFG_B_LO+:2] : st.cfg_c[CFG_C_LO+:2];
        return (c == 2'h3) ? 2 : int'(c);
    endfunction

    function automatic rmtc_state_t regs_default(input rmtc_state_t st, input logic keep);
        rmtc_state_t r;
        r = st;
        r.r0_op = 1'b0;
        r.glide = 8'h00;
        r.shd = '0;
        r.dac = '0;
        r.cfg_ab = 8'h00;
        r.cfg_c = CFG_C_RST;
        r.perr = 1'b0;
        if (!keep) begin
            r.pwr = PWR_ACT;
            r.masks = 3'h0;
            r.usid = USID_RST;
        end
        return r;
    endfunction

    function automatic rmtc_state_t set_pwr(input rmtc_state_t st, input logic [1:0] p);
        rmtc_state_t r;
        r = st;
        if (p == PWR_RESET) begin
            r = regs_default(st, 1'b0);
            r.pwr = PWR_LP;
        end else begin
            r.pwr = p;
        end
        return r;
    endfunction

    function automatic logic [7:0] reg_read(input rmtc_state_t st, input logic [7:0] a);
        case (a)
            REG_MODE:    return {2'h0, st.r0_op, MODE_FIXED, st.pwr};
            REG_GLIDE:   return st.glide;
            REG_DAC_A:   return st.shd[0];
            REG_DAC_B:   return st.shd[1];
            REG_DAC_C:   return st.shd[2];
            REG_TCFG_AB: return st.cfg_ab;
            REG_TCFG_C:  return st.cfg_c;
            REG_SWRST:   return {7'h00, st.perr};
            REG_PTRIG:   return {st.pwr, st.masks, 3'h0};
            REG_DEVID:   return {st.sel_f, PROD_ID};
            REG_MANUF:   return MANUF_ID[7:0];
            REG_USID:    return {2'h0, MANUF_ID[9:8], st.usid};
            default:     return 8'h00;
        endcase
    endfunction

    function automatic rmtc_state_t wr_reg(input rmtc_state_t st, input logic [7:0] a,
                                           input logic [7:0] d);
        rmtc_state_t r;
        int          i;
        r = st;
        i = 0;
        case (a)
            REG_MODE: begin
                r.r0_op = d[OP_BIT];
                r = set_pwr(r, d[1:0]);
            end
            REG_GLIDE:   r.glide = d;
            REG_DAC_A, REG_DAC_B, REG_DAC_C: begin
                i = int'(a) - int'(REG_DAC_A);
                r.shd[i] = d;
                if (r.masks[trig_of(r, i)]) begin
                    r.dac[i] = d;
                end
            end
            REG_TCFG_AB: r.cfg_ab = d;
            REG_TCFG_C:  r.cfg_c = d;
            REG_SWRST: begin
                if (d[SWRST_BIT]) begin
                    r = regs_default(r, 1'b1);
                end else if (d[0]) begin
                    r.perr = 1'b0;
                end
            end
            REG_PTRIG: begin
                r.masks = d[MASK_LO+:3];
                for (int k = 0; k < 3; k++) begin
                    if (d[trig_of(r, k)] && !d[MASK_LO + trig_of(r, k)]) begin
                        r.dac[k] = r.shd[k];
                    end
                end
                r = set_pwr(r, d[7:6]);
            end
            REG_USID:    r.usid = d[3:0];
            default: ;
        endcase
        return r;
    endfunction

    always_comb begin
        n = s;
        rf_bad = 1'b0;
        rf_wr = 1'b0;
        rf_a = 8'h00;
        rf_d = 8'h00;
        own = 1'b0;
        n.sck_q = {s.sck_q[1:0], sclk_i};
        n.sda_q = {s.sda_q[1:0], sdata_i};
        n.vio_q = {s.vio_q[1:0], vio_i};
        n.sel_q = {s.sel_q[1:0], sel_id_i};
        if (s.sck_q[1] == s.sck_q[2]) n.sck_f = s.sck_q[2];
        if (s.sda_q[1] == s.sda_q[2]) n.sda_f = s.sda_q[2];
        if (s.vio_q[1] == s.vio_q[2]) n.vio_f = s.vio_q[2];
        if (s.sel_q[1] == s.sel_q[2]) n.sel_f = s.sel_q[2];
        rise = !s.sck_f && n.sck_f;
        fall = s.sck_f && !n.sck_f;
        f = {s.sh[11:0], n.sda_f};

        // link: sample on falling clock edge, drive on rising edge
        if (n.sck_f) begin
            n.ssc_arm = 1'b0;
        end
        // the slave's own read bits reach the filter as the clock falls: never a start
        if (!n.sck_f && !s.tx_oe && !s.sda_f && n.sda_f) begin
            n.ssc_arm = 1'b1;
        end else if (!n.sck_f && s.ssc_arm && s.sda_f && !n.sda_f) begin
            n.ssc_arm = 1'b0;
            n.lst = L_CMD;
            n.cnt = 4'h0;
            n.par = 1'b0;
            n.tx_oe = 1'b0;
        end else if (fall) begin
            unique case (s.lst)
                L_IDLE: ;
                L_CMD, L_ADDR, L_DATA: begin
                    n.sh = f;
                    n.par = s.par ^ n.sda_f;
                    n.cnt = s.cnt + 4'h1;
                    if (s.cnt == ((s.lst == L_CMD) ? CMD_LAST : FRM_LAST)) begin
                        n.cnt = 4'h0;
                        n.par = 1'b0;
                        n.lst = L_IDLE;
                        if (!(s.par ^ n.sda_f)) begin
                            rf_bad = 1'b1;
                        end else if (s.lst == L_CMD) begin
                            own = (f[12:9] == s.usid);
                            n.bcst = (f[12:9] == BCAST_SA);
                            n.ext = 1'b0;
                            n.bc = 4'h0;
                            n.ra = {3'h0, f[5:1]};
                            if (f[8:6] == CMD_WR && (own || n.bcst)) begin
                                n.lst = L_DATA;
                            end else if (f[8:6] == CMD_RD && own) begin
                                n.lst = L_RPARK;
                            end else if (f[8:5] == CMD_EXT && (own || n.bcst)) begin
                                n.ext = 1'b1;
                                n.bc = f[4:1];
                                n.lst = L_ADDR;
                            end
                        end else if (s.lst == L_ADDR) begin
                            n.ra = f[8:1];
                            n.lst = L_DATA;
                        end else begin
                            if (!s.bcst || s.ra[7:2] == BCAST_PAGE) begin
                                rf_wr = 1'b1;
                                rf_a = s.ra;
                                rf_d = f[8:1];
                            end
                            if (s.ext && s.bc != 4'h0) begin
                                n.bc = s.bc - 4'h1;
                                n.ra = s.ra + 8'h01;
                                n.lst = L_DATA;
                            end
                        end
                    end
                end
                L_RPARK: begin
                    n.lst = L_RD;
                    n.cnt = 4'h0;
                    n.sh = {4'h0, reg_read(s, s.ra), ~^reg_read(s, s.ra)};
                end
                L_RD: begin
                    n.cnt = s.cnt + 4'h1;
                    if (s.cnt == FRM_LAST) begin
                        n.lst = L_RBP;
                    end
                end
                L_RBP: begin
                    n.tx_oe = 1'b0;
                    n.lst = L_IDLE;
                end
            endcase
        end else if (rise) begin
            if (s.lst == L_RD) begin
                n.tx_bit = s.sh[8];
                n.sh = {s.sh[11:0], 1'b0};
                n.tx_oe = 1'b1;
            end else if (s.lst == L_RBP) begin
                n.tx_bit = 1'b0;
                n.tx_oe = 1'b1;
            end
        end

        // register writes: link first, local port in any cycle without a link write
        if (rf_wr) begin
            n = wr_reg(n, rf_a, rf_d);
        end else if (bus_i.wr && bus_i.addr[1:0] == 2'h0) begin
            n = wr_reg(n, {3'h0, bus_i.addr[BUS_AW-1:2]}, bus_i.wdata);
        end
        if (rf_bad) begin
            n.perr = 1'b1;
        end
        n.rdata = (bus_i.rd && bus_i.addr[1:0] == 2'h0) ?
                  reg_read(s, {3'h0, bus_i.addr[BUS_AW-1:2]}) : 8'h00;

        // power modes
        unique case (s.ps)
            PS_SHUTDOWN: begin
                if (n.vio_f) begin
                    n.ps = PS_WAKING;
                    n.acnt = 16'(ACTIVE_CYCLES);
                end
            end
            PS_WAKING: begin
                if (n.pwr == PWR_LP) begin
                    n.ps = PS_LOWPWR;
                end else if (s.acnt <= 16'h0001) begin
                    n.ps = PS_ACTIVE;
                end else begin
                    n.acnt = s.acnt - 16'h0001;
                end
            end
            PS_ACTIVE: begin
                if (n.pwr == PWR_LP) n.ps = PS_LOWPWR;
            end
            PS_LOWPWR: begin
                if (n.pwr == PWR_ACT) begin
                    n.ps = PS_WAKING;
                    n.acnt = 16'(ACTIVE_CYCLES);
                end
            end
        endcase

        if (n.dac != s.dac) begin
            n.scnt = 10'(SETTLE_CYC);
        end else if (s.scnt != 10'h000) begin
            n.scnt = s.scnt - 10'h001;
        end

        if (!n.vio_f) begin
            n = regs_default(n, 1'b0);
            n.ps = PS_SHUTDOWN;
            n.lst = L_IDLE;
            n.tx_oe = 1'b0;
            n.ssc_arm = 1'b0;
            n.cnt = 4'h0;
            n.par = 1'b0;
            n.scnt = 10'h000;
        end
        n.hiz = !(n.ps == PS_ACTIVE && n.r0_op);
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s <= '0;
            s.cfg_c <= CFG_C_RST;
            s.usid <= USID_RST;
            s.ps <= PS_SHUTDOWN;
            s.lst <= L_IDLE;
            s.hiz <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign sdata_o       = s.tx_bit;
    assign sdata_oe_n_o  = !s.tx_oe;
    assign bus_rdata_o   = s.rdata;
    assign dac_o         = s.dac;
    assign out_hiz_o     = s.hiz;
    assign ready_o       = (s.ps == PS_ACTIVE);
    assign settle_busy_o = (s.scnt != 10'h000);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_hiz_shutdown: assert property (!s.vio_f |-> out_hiz_o && !ready_o)
        else $error("outputs not high-z in shutdown");
    a_idle_hiz: assert property (!s.r0_op |-> out_hiz_o)
        else $error("outputs driven in active idle");
    a_lowpwr_hiz: assert property (s.ps == PS_LOWPWR |-> out_hiz_o && !ready_o)
        else $error("outputs driven in low power");
    a_wake_done: assert property ((s.ps == PS_WAKING && s.acnt == 16'h0001 && n.vio_f
        && n.pwr == PWR_ACT) |=> ready_o)
        else $error("activation count did not end in active mode");
    a_bad_frame_drop: assert property (rf_bad |=> $stable(s.dac) && $stable(s.glide)
        && s.perr)
        else $error("frame with bad parity changed registers");
    a_park_low: assert property ((s.lst == L_RBP && rise) |=> s.tx_oe && !s.tx_bit)
        else $error("bus park not driven low");
    a_park_release: assert property ((s.lst == L_RBP && s.tx_oe && fall && n.vio_f)
        |=> !s.tx_oe ##1 !s.tx_oe)
        else $error("bus park not released on falling edge");
    a_pwr_reset: assert property ((rf_wr && rf_a == REG_PTRIG && rf_d[7:6] == PWR_RESET
        && n.vio_f) |=> s.pwr == PWR_LP && s.dac == '0 && s.usid == USID_RST)
        else $error("power field 01b did not reset into low power");
    a_soft_keep: assert property ((rf_wr && rf_a == REG_SWRST && rf_d[SWRST_BIT]
        && n.vio_f) |=> $stable(s.usid) && $stable(s.masks) && s.shd == '0)
        else $error("soft reset touched kept registers");
    a_shadow_hold: assert property ((rf_wr && rf_a == REG_DAC_A && !s.masks[trig_of(s, 0)]
        && n.vio_f) |=> $stable(s.dac) && s.shd[0] == $past(rf_d))
        else $error("unmasked dac write reached destination");
    a_settle_start: assert property ((n.dac != s.dac && n.vio_f) |=> settle_busy_o [*8])
        else $error("settling window not started on update");

    c_read_frame: cover property (s.lst == L_RBP ##1 s.lst == L_IDLE);
    c_trigger_copy: cover property (rf_wr && rf_a == REG_PTRIG && rf_d[2:0] != 3'h0);
    c_wake: cover property (s.ps == PS_WAKING && s.acnt == 16'h0001 ##1 s.ps == PS_ACTIVE);
endmodule // rmtc_core

/* File: tb/rmtc_link_master.sv */
`timescale 1ns/10ps
module rmtc_link_master (
    output logic      sclk_o,
    output logic      sdata_o,
    output logic      drive_o,
    input  wire logic line_i
);
    localparam time HALF = 100;
    initial begin
        sclk_o = 1'b0;
        sdata_o = 1'b0;
        drive_o = 1'b0;
    end
    task automatic tick(input logic b);
        drive_o = 1'b1;
        sdata_o = b;
        sclk_o = 1'b1;
        #HALF sclk_o = 1'b0;
        #HALF;
    endtask
    task automatic ssc();
        drive_o = 1'b1;
        sdata_o = 1'b1;
        #HALF sdata_o = 1'b0;
        #HALF;
    endtask
    // payload msb first, then odd parity unless bad is set
    task automatic frame(input logic [11:0] v, input int n, input logic bad);
        for (int i = n - 1; i >= 0; i--) tick(v[i]);
        tick(~^v ^ bad);
    endtask
    task automatic park();
        sdata_o = 1'b0;
        sclk_o = 1'b1;
        #HALF drive_o = 1'b0;
        sclk_o = 1'b0;
        #HALF;
    endtask
    task automatic wr_reg(input logic [3:0] sa, input logic [4:0] a, input logic [7:0] d,
                          input logic bad);
        ssc();
        frame({sa, 3'b010, a}, 12, 1'b0);
        frame({4'h0, d}, 8, bad);
        park();
    endtask
    // byte count fixed at 2: three data frames
    task automatic ext_wr(input logic [3:0] sa, input logic [7:0] a, input logic [23:0] d);
        ssc();
        frame({sa, 8'h02}, 12, 1'b0);
        frame({4'h0, a}, 8, 1'b0);
        for (int i = 0; i < 3; i++) frame({4'h0, d[8*i+:8]}, 8, 1'b0);
        park();
    endtask
    // slave bits are caught late in each low phase, after its launch has settled
    task automatic rd_reg(input logic [3:0] sa, input logic [4:0] a, output logic [8:0] q);
        ssc();
        frame({sa, 3'b011, a}, 12, 1'b0);
        park();
        for (int i = 8; i >= 0; i--) begin
            sclk_o = 1'b1;
            #HALF sclk_o = 1'b0;
            #(HALF - 5) q[i] = line_i;
            #5;
        end
        sclk_o = 1'b1;
        #HALF sclk_o = 1'b0;
        #HALF;
    endtask
endmodule // rmtc_link_master

/* File: tb/rmtc_core_tb_top.sv */
`timescale 1ns/10ps
module rmtc_core_tb_top;
    import rmtc_pkg::*;
    localparam logic [9:0] MANUF = 10'h155; // arbitrary value
    localparam logic [5:0] PROD  = 6'h2a;   // arbitrary value
    localparam int         LIMIT = 20000;
    logic              clk, rst, vio, sd_o, sd_oe_n, hiz, rdy, busy, m_sclk, m_sd, m_drv;
    logic [1:0]        sel;
    rmtc_bus_t         bus;
    logic [7:0]        rdata, q, va, vb;
    rmtc_dac_t         dac;
    logic [23:0]       vx;
    logic [8:0]        rq;
    int                seed = 46;
    int                miscompares = 0;
    int                check_count = 0;
    int                cyc = 0;
    wire               line;
    // released line rests low
    assign line = !sd_oe_n ? sd_o : (m_drv ? m_sd : 1'b0);
    rmtc_core #(.ACTIVE_CYCLES(20), .MANUF_ID(MANUF), .PROD_ID(PROD)) i_dut (
        .clk_i(clk), .rst_i(rst), .vio_i(vio), .sclk_i(m_sclk), .sdata_i(line),
        .sdata_o(sd_o), .sdata_oe_n_o(sd_oe_n), .sel_id_i(sel), .bus_i(bus),
        .bus_rdata_o(rdata), .dac_o(dac), .out_hiz_o(hiz), .ready_o(rdy),
        .settle_busy_o(busy));
    rmtc_link_master i_master (.sclk_o(m_sclk), .sdata_o(m_sd), .drive_o(m_drv), .line_i(line));
    function automatic logic [7:0] usid_reg();
        return {2'b00, MANUF[9:8], USID_RST};
    endfunction
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic waitc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wait_rdy();
        repeat (300) if (rdy !== 1'b1) @(posedge clk);
        #1;
    endtask
    task automatic bwr(input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: {idx[4:0], 2'b00}, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask
    task automatic brd(input logic [7:0] idx);
        @(posedge clk);
        bus <= '{addr: {idx[4:0], 2'b00}, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 q = rdata;
    endtask
    task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
        brd(idx);
        chk8(q, exp);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            miscompares++;
            tally_and_finish();
        end
    end
    initial begin
        rst = 1'b1;
        vio = 1'b1;
        bus = '0;
        sel = 2'($random(seed));
        repeat (6) @(posedge clk);
        chk8(dac[0] | dac[1] | dac[2], 8'h00);
        chk1(hiz, 1'b1);
        rst <= 1'b0;
        wait_rdy();
        chk1(rdy, 1'b1);
        chk1(hiz, 1'b1);
        rchk(REG_MODE, 8'h08);
        rchk(REG_TCFG_C, CFG_C_RST);
        rchk(REG_USID, usid_reg());
        rchk(REG_DEVID, {sel, PROD});
        rchk(8'h10, 8'h00);
        bwr(REG_MODE, 8'h28);
        waitc(3);
        chk1(hiz, 1'b0);
        va = 8'($random(seed)) | 8'h01;
        vb = 8'($random(seed)) | 8'h01;
        i_master.wr_reg(USID_RST, 5'h02, va, 1'b0);
        waitc(8);
        chk8(dac[0], 8'h00);
        rchk(REG_DAC_A, va);
        bwr(REG_TCFG_AB, 8'h04);
        i_master.wr_reg(USID_RST, 5'h03, vb, 1'b0);
        i_master.wr_reg(USID_RST, 5'h1c, 8'h01, 1'b0);
        waitc(8);
        chk8(dac[0], va);
        chk8(dac[1], 8'h00);
        chk1(busy, 1'b1);
        i_master.wr_reg(USID_RST, 5'h1c, 8'h02, 1'b0);
        waitc(8);
        chk8(dac[1], vb);
        waitc(SETTLE_CYC + 40);
        chk1(busy, 1'b0);
        i_master.wr_reg(USID_RST, 5'h02, ~va, 1'b1);
        waitc(8);
        rchk(REG_DAC_A, va);
        rchk(REG_SWRST, 8'h01);
        bwr(REG_SWRST, 8'h01);
        bwr(REG_PTRIG, 8'h38);
        vx = 24'($random(seed));
        i_master.ext_wr(USID_RST, REG_DAC_A, vx);
        waitc(8);
        chk8(dac[0], vx[7:0]);
        chk8(dac[1], vx[15:8]);
        chk8(dac[2], vx[23:16]);
        chk1(busy, 1'b1);
        i_master.rd_reg(USID_RST, 5'h1f, rq);
        chk8(rq[8:1], usid_reg());
        chk1(rq[0], ~^usid_reg());
        waitc(20);
        chk1(sd_oe_n, 1'b1);
        i_master.wr_reg(BCAST_SA, 5'h1c, 8'hb8, 1'b0);
        waitc(8);
        chk1(rdy, 1'b0);
        chk1(hiz, 1'b1);
        brd(REG_MODE);
        chk8({6'h0, q[1:0]}, {6'h0, PWR_LP});
        bwr(REG_GLIDE, 8'h5a);
        rchk(REG_GLIDE, 8'h5a);
        i_master.wr_reg(BCAST_SA, 5'h01, 8'h33, 1'b0);
        waitc(8);
        rchk(REG_GLIDE, 8'h5a);
        bwr(REG_MODE, 8'h28);
        wait_rdy();
        chk1(rdy, 1'b1);
        rchk(REG_PTRIG, 8'h38);
        i_master.wr_reg(USID_RST, 5'h1a, 8'h80, 1'b0);
        rchk(REG_GLIDE, 8'h00);
        rchk(REG_PTRIG, 8'h38);
        rchk(REG_MODE, 8'h08);
        bwr(REG_TCFG_C, 8'h00);
        i_master.wr_reg(USID_RST, 5'h1c, 8'h78, 1'b0);
        waitc(4);
        rchk(REG_TCFG_C, CFG_C_RST);
        rchk(REG_PTRIG, 8'h80);
        chk1(rdy, 1'b0);
        bwr(REG_PTRIG, 8'hb8);
        bwr(REG_DAC_A, 8'h7f);
        waitc(10);
        chk8(dac[0], 8'h7f);
        vio <= 1'b0;
        waitc(8);
        chk8(dac[0], 8'h00);
        chk1(hiz, 1'b1);
        tally_and_finish();
    end
endmodule // rmtc_core_tb_top
